// file: src/wdt_top.sv
/*
 * Watchdog timer with AXI4-Lite register slave and a masked interrupt.
 * Assumes one 100 MHz clock, an AXI4-Lite master with one access of each kind
 * under way at a time, and a system reset controller that consumes o_sys_reset.
 */
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
//
// Contract
// - Counter runs freely on system clock; software restart clears it to zero.
// - Two-bit select picks timeout of 2^15, 2^18, 2^21 or 2^24 cycles.
// - On timeout without restart, raise interrupt when interrupt is enabled.
// - Reset falls exactly 512 cycles after the timeout point, any selection.
// - No restart within the 512-cycle window means system reset at its end when reset is enabled.
module wdt_top
  import wdt_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst_n,
  input  wire logic          i_ce,
  // AXI4-Lite slave.
  input  wire wdt_axi_req_t  i_axi,
  output wdt_axi_rsp_t       o_axi,
  // Events.
  output logic               o_irq,
  output logic               o_sys_reset
);

  typedef struct packed {
    logic [3:0]  ctrl;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        restart;
  } wdt_top_st_t;

  wdt_top_st_t       s_q, s_d;
  logic              tmo_w;
  logic              rst_w;
  logic [CNT_W-1:0]  cnt_w;
  logic              wr_go;
  logic              rd_go;
  logic [1:0]        w1c;

  ////////////////////////////////////////////////////////////////////////////////
  // Counting core.
  wdt_core wdt_core_inst (
    .i_clk_sys        (i_clk_sys),
    .i_rst_n          (i_rst_n),
    .i_ce             (i_ce),
    .i_timeout_select (s_q.ctrl[CTRL_SEL_LSB +: 2]),
    .i_restart        (s_q.restart),
    .i_rst_en         (s_q.ctrl[CTRL_REN_BIT]),
    .o_timeout        (tmo_w),
    .o_reset          (rst_w),
    .o_count          (cnt_w)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register slave and event logic.
  assign wr_go = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign rd_go = i_axi.arvalid && !s_q.rvalid;

  always_comb begin
    s_d         = s_q;
    s_d.restart = 1'b0;
    w1c         = 2'b00;
    if (i_axi.awvalid && !s_q.aw_got) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = i_axi.awaddr;
    end
    if (i_axi.wvalid && !s_q.w_got) begin
      s_d.w_got = 1'b1;
      s_d.wdata = i_axi.wdata;
      s_d.wstrb = i_axi.wstrb;
    end
    if (wr_go) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      unique case (s_q.awaddr)
        ADDR_CTRL:    if (s_q.wstrb[0]) s_d.ctrl = s_q.wdata[3:0];
        ADDR_STATUS:  if (s_q.wstrb[0]) w1c = s_q.wdata[1:0];
        ADDR_MASK:    if (s_q.wstrb[0]) s_d.mask = s_q.wdata[1:0];
        ADDR_RESTART: if (s_q.wstrb[0] && s_q.wdata[0]) s_d.restart = 1'b1;
        ADDR_COUNT:   s_d.bresp = RESP_OKAY;
        default:      s_d.bresp = RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && i_axi.bready) begin
      s_d.bvalid = 1'b0;
    end
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      unique case (i_axi.araddr)
        ADDR_CTRL:    s_d.rdata = {28'h000_0000, s_q.ctrl};
        ADDR_STATUS:  s_d.rdata = {30'h0000_0000, s_q.status};
        ADDR_MASK:    s_d.rdata = {30'h0000_0000, s_q.mask};
        ADDR_RESTART: s_d.rdata = 32'h0000_0000;
        ADDR_COUNT:   s_d.rdata = {7'h00, cnt_w};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && i_axi.rready) begin
      s_d.rvalid = 1'b0;
    end
    s_d.status = s_q.status & ~w1c;
    if (tmo_w) s_d.status[STAT_TMO_BIT] = 1'b1;
    if (rst_w) s_d.status[STAT_RST_BIT] = 1'b1;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q      <= '0;
      s_q.ctrl <= CTRL_RST_VAL;
      s_q.mask <= MASK_RST_VAL;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_irq = s_q.ctrl[CTRL_IEN_BIT] && |(s_q.status & s_q.mask);
  assign o_sys_reset = rst_w;

  assign o_axi.awready = !s_q.aw_got;
  assign o_axi.wready  = !s_q.w_got;
  assign o_axi.bvalid  = s_q.bvalid;
  assign o_axi.bresp   = s_q.bresp;
  assign o_axi.arready = !s_q.rvalid;
  assign o_axi.rvalid  = s_q.rvalid;
  assign o_axi.rdata   = s_q.rdata;
  assign o_axi.rresp   = s_q.rresp;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  flag_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && tmo_w |=> s_q.status[STAT_TMO_BIT]) else $error("timeout flag not set");
  irq_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !s_q.ctrl[CTRL_IEN_BIT] |-> !o_irq) else $error("irq while disabled");
  reset_gap_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_sys_reset |-> $past(s_q.status[STAT_TMO_BIT], 1) || $past(tmo_w, 512))
    else $error("reset without prior timeout");
  reset_en_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_sys_reset |-> $past(s_q.ctrl[CTRL_REN_BIT])) else $error("reset while disabled");
  sel_min_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    tmo_w |-> cnt_w >= CNT_W'(32768)) else $error("timeout before 2^15");
  ctrl_wr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && wr_go && s_q.awaddr == ADDR_CTRL && s_q.wstrb[0]
    |=> s_q.ctrl == $past(s_q.wdata[3:0])) else $error("ctrl write lost");
  restart_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && s_q.restart |=> cnt_w == '0) else $error("restart ignored");
  bresp_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && wr_go |=> o_axi.bvalid) else $error("write not answered");
  rd_lat_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && rd_go |=> o_axi.rvalid)
    else $error("read not answered");
  rvalid_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata))
    else $error("read data dropped");
  rd_count_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && rd_go && i_axi.araddr == ADDR_COUNT |=> o_axi.rdata[CNT_W-1:0] == $past(cnt_w))
    else $error("count read wrong");
  rd_err_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && rd_go && i_axi.araddr > ADDR_COUNT |=> o_axi.rresp == RESP_SLVERR)
    else $error("bad read address accepted");
  wr_err_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && wr_go && s_q.awaddr > ADDR_COUNT |=> o_axi.bresp == RESP_SLVERR)
    else $error("bad write address accepted");
  mask_wr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && wr_go && s_q.awaddr == ADDR_MASK && s_q.wstrb[0]
    |=> s_q.mask == $past(s_q.wdata[1:0])) else $error("mask write lost");
  restart_wr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && wr_go && s_q.awaddr == ADDR_RESTART && s_q.wstrb[0] && s_q.wdata[0]
    |=> s_q.restart) else $error("restart write lost");
  cnt_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_rst_n && i_ce && !s_q.restart |=> cnt_w == $past(cnt_w) + 1'b1)
    else $error("counter did not step");
  ce_freeze_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_rst_n && !i_ce |=> $stable(s_q) && $stable(cnt_w))
    else $error("state moved while frozen");
  irq_raise_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && tmo_w && !wr_go && s_q.ctrl[CTRL_IEN_BIT] && s_q.mask[STAT_TMO_BIT] |=> o_irq)
    else $error("enabled timeout gave no interrupt");
  rst_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && o_sys_reset |=> !o_sys_reset)
    else $error("reset pulse too long");
  rst_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && o_sys_reset |=> s_q.status[STAT_RST_BIT])
    else $error("reset flag not set");
  clr_tmo_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && wr_go && s_q.awaddr == ADDR_STATUS && s_q.wstrb[0]
    && s_q.wdata[STAT_TMO_BIT] && !tmo_w |=> !s_q.status[STAT_TMO_BIT])
    else $error("timeout flag not cleared");
  flag_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && s_q.status[STAT_TMO_BIT] && !(wr_go && s_q.awaddr == ADDR_STATUS)
    |=> s_q.status[STAT_TMO_BIT]) else $error("timeout flag lost");

  cov_tmo_c:   cover property (@(posedge i_clk_sys) tmo_w);
  cov_rst_c:   cover property (@(posedge i_clk_sys) o_sys_reset);
  cov_irq_c:   cover property (@(posedge i_clk_sys) o_irq);
  cov_rstrt_c: cover property (@(posedge i_clk_sys) s_q.restart && cnt_w == '0);
  cov_clr_c:   cover property (@(posedge i_clk_sys) wr_go && s_q.awaddr == ADDR_STATUS);

endmodule

// file: src/wdt_pkg.sv
/*
 * Package for the watchdog block: register map, field positions, reset values,
 * timing counts, the packed structs that carry bus channels and the state encoding.
 * Assumes a single 100 MHz system clock and an AXI4-Lite master with 32-bit data.
 */
package wdt_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned CNT_W           = 25;
  localparam int unsigned RESET_DELAY_CYC = 512;
  localparam logic [4:0]  TMO_EXP_0       = 5'h0F;
  localparam logic [4:0]  TMO_EXP_1       = 5'h12;
  localparam logic [4:0]  TMO_EXP_2       = 5'h15;
  localparam logic [4:0]  TMO_EXP_3       = 5'h18;
  localparam logic [9:0]  GRACE_LAST      = 10'(RESET_DELAY_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses.
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_MASK    = 8'h08;
  localparam logic [7:0] ADDR_RESTART = 8'h0C;
  localparam logic [7:0] ADDR_COUNT   = 8'h10;

  // Control fields.
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_IEN_BIT = 2;
  localparam int unsigned CTRL_REN_BIT = 3;
  localparam logic [3:0]  CTRL_RST_VAL = 4'h0;

  // Status and mask fields; the timeout bit and the reset bit are both interrupt events.
  localparam int unsigned STAT_TMO_BIT = 0;
  localparam int unsigned STAT_RST_BIT = 1;
  localparam logic [1:0]  MASK_RST_VAL = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } wdt_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } wdt_axi_rsp_t;

  typedef enum logic [1:0] {
    WDT_ST_RUN   = 2'b00,
    WDT_ST_GRACE = 2'b01,
    WDT_ST_FIRED = 2'b10
  } wdt_state_t;

endpackage

// file: src/wdt_core.sv
/*
 * Watchdog counting core: free-running counter, timeout detect and the
 * 512-cycle grace window that ends in a one-cycle reset pulse when i_rst_en is set.
 * Assumes restart, select and enable come from synchronous register logic.
 */
module wdt_core
  import wdt_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  // Control.
  input  wire logic [1:0]       i_timeout_select,
  input  wire logic             i_restart,
  input  wire logic             i_rst_en,
  // Status.
  output logic                  o_timeout,
  output logic                  o_reset,
  output logic [CNT_W-1:0]      o_count
);

  typedef struct packed {
    wdt_state_t       st;
    logic [CNT_W-1:0] cnt;
    logic [9:0]       grace;
    logic             tmo;
    logic             rst;
  } wdt_core_st_t;

  wdt_core_st_t s_q, s_d;
  logic [4:0]   exp_w;

  always_comb begin
    unique case (i_timeout_select)
      2'b00: exp_w = TMO_EXP_0;
      2'b01: exp_w = TMO_EXP_1;
      2'b10: exp_w = TMO_EXP_2;
      2'b11: exp_w = TMO_EXP_3;
    endcase
  end

  always_comb begin
    s_d     = s_q;
    s_d.tmo = 1'b0;
    s_d.rst = 1'b0;
    s_d.cnt = s_q.cnt + 1'b1;
    unique case (s_q.st)
      WDT_ST_RUN: begin
        if (s_q.cnt == CNT_W'((CNT_W'(1) << exp_w) - 1'b1)) begin
          s_d.tmo   = 1'b1;
          s_d.st    = WDT_ST_GRACE;
          s_d.grace = '0;
        end
      end
      WDT_ST_GRACE: begin
        s_d.grace = s_q.grace + 1'b1;
        if (s_q.grace == GRACE_LAST) begin
          s_d.rst = i_rst_en;
          s_d.st  = WDT_ST_FIRED;
        end
      end
      WDT_ST_FIRED: begin
      end
      default: s_d.st = WDT_ST_RUN;
    endcase
    // restart clears counter.
    // A restart that lands on the threshold or the window end wins, so no stray pulse escapes.
    if (i_restart) begin
      s_d.cnt   = '0;
      s_d.grace = '0;
      s_d.st    = WDT_ST_RUN;
      s_d.tmo   = 1'b0;
      s_d.rst   = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '{st: WDT_ST_RUN, cnt: '0, grace: '0, tmo: 1'b0, rst: 1'b0};
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_timeout = s_q.tmo;
  assign o_reset   = s_q.rst;
  assign o_count   = s_q.cnt;

  grace_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(s_q.st == WDT_ST_GRACE) && i_ce ##1 (i_ce && !i_restart && i_rst_en) [*8]
    |-> s_q.st == WDT_ST_GRACE) else $error("grace window ended early");
  restart_clr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && i_restart |=> s_q.cnt == '0 && !o_reset) else $error("restart did not clear");

endmodule

// file: testbench/wdt_top_test.sv
/*
 * Self-checking bench for the watchdog top: register map, select codes,
 * counter restart, periodic service, timeout interrupt, masking and reset pulse.
 * Assumes wdt_pkg and wdt_top are compiled first; one 100 MHz clock, i_ce high except for one 200-cycle freeze.
 */
module wdt_top_test
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          i_clk_sys;
  logic          i_rst_n;
  logic          i_ce;
  wdt_axi_req_t  i_axi;
  wdt_axi_rsp_t  o_axi;
  logic          o_irq;
  logic          o_sys_reset;
  int            fails;
  int            tests_run;
  logic [31:0]   seed = 32'h0000_81fb;
  logic [31:0]   rd;
  logic [31:0]   d;
  logic [1:0]    rs;
  int            c1;
  int            c2;
  logic          bad;

  wdt_top wdt_top_inst (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_ce        (i_ce),
    .i_axi       (i_axi),
    .o_axi       (o_axi),
    .o_irq       (o_irq),
    .o_sys_reset (o_sys_reset)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Timeout length in cycles for a select code.
  function automatic int tmo_len(input logic [1:0] sel);
    return 1 << (15 + 3 * int'(sel));
  endfunction

  task automatic wrap_up();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Bus handshakes add a cycle or two of slack, so cycle counts carry a tolerance.
  task automatic cmp_near(input int g, input int e, input int tol);
    tests_run++;
    if (g < e - tol || g > e + tol) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic lost();
    fails++;
    $display("BAD t=%0t got=%h exp=%h", $time, 0, 1);
    wrap_up();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge i_clk_sys);
    i_axi.awaddr  <= a;
    i_axi.wdata   <= v;
    i_axi.wstrb   <= 4'hf;
    i_axi.awvalid <= 1'b1;
    i_axi.wvalid  <= 1'b1;
    i_axi.bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk_sys);
      if (o_axi.awready) i_axi.awvalid <= 1'b0;
      if (o_axi.wready) i_axi.wvalid <= 1'b0;
      if (o_axi.bvalid) begin
        r = o_axi.bresp;
        i_axi.bready <= 1'b0;
        break;
      end
    end
    if (n >= 50) lost();
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge i_clk_sys);
    i_axi.araddr  <= a;
    i_axi.arvalid <= 1'b1;
    i_axi.rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk_sys);
      if (o_axi.arready) i_axi.arvalid <= 1'b0;
      if (o_axi.rvalid) begin
        v = o_axi.rdata;
        r = o_axi.rresp;
        i_axi.rready <= 1'b0;
        break;
      end
    end
    if (n >= 50) lost();
  endtask

  task automatic wait_for(input logic rst, input int lim, output int cyc);
    cyc = 0;
    while ((rst ? o_sys_reset : o_irq) !== 1'b1) begin
      @(negedge i_clk_sys);
      cyc++;
      if (cyc > lim) lost();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rst_n = 1'b0;
    i_ce    = 1'b1;
    i_axi   = '0;
    fails   = 0;
    tests_run = 0;
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      axr(8'(ADDR_CTRL + 8'(4 * i)), rd, rs);
      cmp_val(rd, 32'h0000_0000);
      cmp_val(32'(rs), 32'(RESP_OKAY));
    end
    axr(8'h14, rd, rs);
    cmp_val({rd[29:0], rs}, {30'h0, RESP_SLVERR});
    axw(8'h14, rnd(), rs);
    cmp_val(32'(rs), 32'(RESP_SLVERR));
    $display("test register map done");
    for (int k = 0; k < 4; k++) begin
      d = (rnd() & 32'hffff_fffc) | 32'(k);
      axw(ADDR_CTRL, d, rs);
      axr(ADDR_CTRL, rd, rs);
      cmp_val(rd, {28'h0, d[3:0]});
    end
    $display("test select codes done");
    axw(ADDR_RESTART, 32'h0000_0001, rs);
    axr(ADDR_COUNT, rd, rs);
    c1 = int'(rd);
    cmp_near(c1, 2, 3);
    repeat (100) @(posedge i_clk_sys);
    axr(ADDR_COUNT, rd, rs);
    cmp_near(int'(rd) - c1, 102, 2);
    c1 = int'(rd);
    i_ce <= 1'b0;
    repeat (200) @(posedge i_clk_sys);
    i_ce <= 1'b1;
    axr(ADDR_COUNT, rd, rs);
    cmp_near(int'(rd) - c1, 3, 1);
    $display("test counter restart done");
    axw(ADDR_CTRL, 32'h0000_000c, rs);
    axw(ADDR_MASK, 32'h0000_0003, rs);
    bad = 1'b0;
    repeat (2) begin
      c1 = 2000 + int'(rnd() % 8000);
      repeat (c1) begin
        @(negedge i_clk_sys);
        if (o_irq !== 1'b0 || o_sys_reset !== 1'b0) bad = 1'b1;
      end
      axw(ADDR_RESTART, 32'h0000_0001, rs);
    end
    cmp_val(32'(bad), 32'h0000_0000);
    $display("test periodic service done");
    wait_for(1'b0, 40000, c1);
    cmp_near(c1, tmo_len(2'b00), 4);
    wait_for(1'b1, 600, c2);
    cmp_near(c2, 512, 1);
    @(negedge i_clk_sys);
    cmp_val(32'(o_sys_reset), 32'h0000_0000);
    axr(ADDR_STATUS, rd, rs);
    cmp_val(rd, 32'h0000_0003);
    axw(ADDR_MASK, 32'h0000_0000, rs);
    @(negedge i_clk_sys);
    cmp_val(32'(o_irq), 32'h0000_0000);
    axw(ADDR_MASK, 32'h0000_0003, rs);
    @(negedge i_clk_sys);
    cmp_val(32'(o_irq), 32'h0000_0001);
    axw(ADDR_CTRL, 32'h0000_0008, rs);
    @(negedge i_clk_sys);
    cmp_val(32'(o_irq), 32'h0000_0000);
    axw(ADDR_CTRL, 32'h0000_000c, rs);
    axw(ADDR_STATUS, 32'h0000_0003, rs);
    axr(ADDR_STATUS, rd, rs);
    cmp_val({rd[30:0], o_irq}, 32'h0000_0000);
    $display("test timeout and reset done");
    axw(ADDR_CTRL, 32'h0000_0004, rs);
    axw(ADDR_RESTART, 32'h0000_0001, rs);
    wait_for(1'b0, 40000, c1);
    cmp_near(c1, tmo_len(2'b00), 4);
    bad = 1'b0;
    repeat (600) begin
      @(negedge i_clk_sys);
      if (o_sys_reset !== 1'b0) bad = 1'b1;
    end
    cmp_val(32'(bad), 32'h0000_0000);
    axr(ADDR_STATUS, rd, rs);
    cmp_val(rd, 32'h0000_0001);
    $display("test reset disabled done");
    wrap_up();
  end

endmodule
